// File: include/dca_map.vh
`ifndef DCA_MAP_VH
`define DCA_MAP_VH
// Register byte offsets
`define DCA_OFS_CARRIER 8'h00
`define DCA_OFS_SMOOTH  8'h04
`define DCA_OFS_RANGE   8'h08
`define DCA_OFS_THERM   8'h0c
`define DCA_OFS_ASSIGN  8'h10
`define DCA_OFS_GAINF   8'h14
`define DCA_OFS_WPROT   8'h18
`define DCA_OFS_STATUS  8'h1c
// Field positions
`define DCA_F_SOFT      4
`define DCA_F_AUTO      8
`define DCA_F_SEC_LSB   8
// Reset values
`define DCA_RST_CARRIER 4'h1
`define DCA_RST_SOFT    1'h1
`define DCA_RST_AUTO    1'h0
`define DCA_RST_SMOOTH  8'h00
`define DCA_RST_PRIM    4'h1
`define DCA_RST_SEC     2'h0
`define DCA_RST_THERM   16'h270f
`define DCA_RST_ASSIGN  25'h0000000
`define DCA_RST_GAINF   12'h1f4
`define DCA_RST_WPROT   2'h0
// Codes and limits
`define DCA_THERM_OFF   16'h270f
`define DCA_AUX_FUNC    5'h04
`define DCA_CARR_MIN_RED 4'h3
`define DCA_CARR_RED    4'h2
`define DCA_CARR_SOFT_MAX 4'h5
`define DCA_LOAD_LIMIT  8'h55
`define DCA_SMOOTH_MAX  8'hc8
`define DCA_GAINF_MAX   12'hfa0
`define DCA_WP_ALL      2'h2
`define DCA_MA_ZERO     10'h0cd
// Load must stay high this long (ns) before the carrier drops
`define DCA_HOLD_NS     1000
`define DCA_CLK_NS      8
`define DCA_HOLD_CYC    ((`DCA_HOLD_NS + `DCA_CLK_NS - 1) / `DCA_CLK_NS)
`endif

// File: src/dca_top.v
// Operation
// RULE1: Auto reduce on, carrier at least 3kHz, load at least 85% held: carrier drops to 2kHz.
// RULE2: Auto reduce select 0 keeps the configured carrier whatever the load.
// RULE3: Carrier select 0..15 in kHz, 0 is 0.7kHz, 15 is 14.5kHz, reset 1.
// RULE4: Auto reduce select 1 lowers the carrier as load rises.
// RULE5: Operator should disable fast current limit when carrier is 1kHz or less.
// RULE6: Carrier and soft carrier settings stay writable while running, protect at 0.
// RULE7: Smoothing gain 0..200%, reset 0, modulates output frequency to damp torque swings.
// RULE8: Operator tunes smoothing from 100% stepwise at the worst vibration speed.
// RULE9: Primary range 0:0-10V, 1:0-5V (reset), 10:0-10V and 11:0-5V reversible.
// RULE10: Secondary range 0:4-20mA (reset), 1:0-5V, 2:0-10V.
// RULE11: Aux off selects primary, aux on selects secondary; reversal follows primary select.
// RULE12: Aux signal comes from an input only if an assign field holds code 4.
// RULE13: Thermistor level other than 9999 stops primary input acting as command.
// RULE14: Gain frequency sets full-scale output directly; range select leaves ramps alone.
// RULE15: Operator keeps the voltage/current switch consistent with secondary range.
//
// The placing of the registers and the Wishbone register port were decided locally.
`include "dca_map.vh"
module dca_top (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        run_i,
  input  wire [7:0]  load_pct_i,
  input  wire [4:0]  din_i,
  input  wire [9:0]  prim_adc_i,
  input  wire [9:0]  sec_adc_i,
  output reg  [3:0]  carrier_code_o,
  output reg  [7:0]  carrier_tenths_o,
  output reg         soft_carrier_en_o,
  output reg         sec_current_mode_o,
  output reg         main_src_sec_o,
  output reg         reversible_o,
  output reg  [15:0] freq_cmd_o
);

  // Carrier code to 0.1kHz units; ends of the range are not integer kHz
  function [7:0] dca_tenths;
    input [3:0] code;
    begin
      case (code)
        // Ends of the range are not whole kHz
        4'h0: begin
          dca_tenths = 8'h07;
        end
        4'hf: begin
          dca_tenths = 8'h91;
        end
        default: begin
          dca_tenths = {4'h0, code} * 8'h0a;
        end
      endcase
    end
  endfunction

  // Input sample to 0..1023 of full scale; mode 0:10V 1:5V 2:4-20mA
  function [9:0] dca_norm;
    input [9:0] adc;
    input [1:0] mode;
    reg   [12:0] t;
    begin
      t = 13'h0000;
      case (mode)
        // Full 10V span maps one to one
        2'h0: begin
          dca_norm = adc;
        end
        // Half span: double the sample and clip at full scale
        2'h1: begin
          dca_norm = adc[9] ? 10'h3ff : {adc[8:0], 1'b0};
        end
        // Live zero at 4mA; below it the normalised sample stays at zero
        2'h2: begin
          t = (adc < `DCA_MA_ZERO) ? 13'h0000 : ({3'h0, adc - `DCA_MA_ZERO} * 13'h0005) >> 2;
          dca_norm = (t > 13'h03ff) ? 10'h3ff : t[9:0];
        end
        default: begin
          dca_norm = adc;
        end
      endcase
    end
  endfunction

  // Primary range codes that the selector takes; anything else is refused
  function dca_prim_ok;
    input [3:0] code;
    begin
      case (code)
        4'h0, 4'h1, 4'ha, 4'hb: dca_prim_ok = 1'b1;
        default:                dca_prim_ok = 1'b0;
      endcase
    end
  endfunction

  // Configuration registers: carrier group
  reg [3:0]  carrier_freq_select;
  reg        soft_carrier_select;
  reg        carrier_auto_reduce_select;
  reg [7:0]  speed_smoothing_gain;
  // Analog input group
  reg [3:0]  primary_input_range_select;
  reg [1:0]  secondary_input_range_select;
  // Protection and terminal assignment
  reg [15:0] thermistor_protect_level;
  reg [24:0] input_function_assign;
  // Full-scale frequencies and write lock
  reg [11:0] primary_gain_frequency;
  reg [11:0] secondary_gain_frequency;
  reg [1:0]  write_protect_select;

  // Internal state
  reg [15:0] hold_cnt;
  reg        reduced;
  reg [11:0] load_avg;
  reg [15:0] main_cmd;

  // Bus decode; ack masks the request so a strobe held through the ack cycle is not taken twice
  wire        acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr  = acc & wb_we_i;
  wire [31:0] wm  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] cur_word;
  wire [31:0] nw  = (cur_word & ~wm) | (wb_dat_i & wm);

  // Carrier and lock writes pass at any time; others only stopped or fully unlocked
  // The lock itself stays reachable, or software could never unlock it while running
  wire wr_open = ~run_i | (write_protect_select == `DCA_WP_ALL)
               | (wb_adr_i == `DCA_OFS_WPROT)
               | (wb_adr_i == `DCA_OFS_CARRIER); // see RULE6

  // Auxiliary signal from any input assigned the aux function
  wire [4:0] aux_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_aux
      assign aux_hit[gi] = din_i[gi]
        & (input_function_assign[gi*5 +: 5] == `DCA_AUX_FUNC); // see RULE12
    end
  endgenerate
  wire aux_on = |aux_hit;

  // Secondary range to normaliser mode; code 0 is the live-zero current loop
  reg [1:0] sec_mode;
  always @* begin
    case (secondary_input_range_select)
      2'h0:    sec_mode = 2'h2; // see RULE10
      2'h1:    sec_mode = 2'h1;
      2'h2:    sec_mode = 2'h0;
      default: sec_mode = 2'h0;
    endcase
  end

  // Selection and range decode
  wire        use_sec   = aux_on; // see RULE11
  wire        prim_off  = thermistor_protect_level != `DCA_THERM_OFF; // see RULE13
  wire        rev       = primary_input_range_select[3]; // see RULE9
  wire [1:0]  prim_mode = primary_input_range_select[0] ? 2'h1 : 2'h0; // see RULE9
  wire [9:0]  pos  = use_sec ? dca_norm(sec_adc_i, sec_mode) : dca_norm(prim_adc_i, prim_mode);
  wire [11:0] gain = use_sec ? secondary_gain_frequency : primary_gain_frequency;
  wire [21:0] prod = {12'h000, pos} * {10'h000, gain};
  wire [11:0] mag  = prod[21:10]; // see RULE14

  // Reversible: lower half of the span is reverse, centre is zero
  reg [15:0] next_main_cmd;
  always @* begin
    if (~use_sec & prim_off) begin
      next_main_cmd = 16'h0000; // see RULE13
    end else if (rev) begin
      next_main_cmd = {3'h0, mag, 1'b0} - {4'h0, gain}; // see RULE11
    end else begin
      next_main_cmd = {4'h0, mag};
    end
  end

  // Smoothing: deviation of load from its running mean, scaled by gain
  wire signed [8:0]  load_dev = $signed({1'b0, load_pct_i}) - $signed({1'b0, load_avg[11:4]});
  wire signed [17:0] corr     = load_dev * $signed({1'b0, speed_smoothing_gain}); // see RULE7
  // Keep the sign: a plain part-select would turn a negative correction positive
  wire signed [15:0] corr_s   = {{4{corr[17]}}, corr[17:6]};
  wire [15:0]        next_freq = main_cmd - corr_s; // see RULE7

  // Effective carrier after load reduction
  wire [3:0] eff_code = reduced ? `DCA_CARR_RED : carrier_freq_select; // see RULE2

  // Word view of each register for read-back and masked writes
  function [31:0] dca_read;
    input [7:0] a;
    begin
      case (a)
        `DCA_OFS_CARRIER: dca_read = {23'h0, carrier_auto_reduce_select, 3'h0,
                                      soft_carrier_select, carrier_freq_select};
        `DCA_OFS_SMOOTH:  dca_read = {24'h0, speed_smoothing_gain};
        `DCA_OFS_RANGE:   dca_read = {22'h0, secondary_input_range_select, 4'h0,
                                      primary_input_range_select};
        `DCA_OFS_THERM:   dca_read = {16'h0, thermistor_protect_level};
        `DCA_OFS_ASSIGN:  dca_read = {7'h0, input_function_assign};
        `DCA_OFS_GAINF:   dca_read = {4'h0, secondary_gain_frequency,
                                      4'h0, primary_gain_frequency};
        `DCA_OFS_WPROT:   dca_read = {30'h0, write_protect_select};
        `DCA_OFS_STATUS:  dca_read = {8'h0, dca_tenths(eff_code), 7'h00, aux_on,
                                      prim_off, rev, use_sec, reduced, eff_code};
        default:          dca_read = 32'h0000_0000;
      endcase
    end
  endfunction
  assign cur_word = dca_read(wb_adr_i);

  // Bus slave: one-cycle ack, unmapped reads zero and writes dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? cur_word : 32'h0000_0000;
    end
  end

  // Register writes; out-of-range values are refused, old value kept
  always @(posedge clk_i) begin
    if (rst_i) begin
      carrier_freq_select          <= `DCA_RST_CARRIER; // see RULE3
      soft_carrier_select          <= `DCA_RST_SOFT;
      carrier_auto_reduce_select   <= `DCA_RST_AUTO;
      speed_smoothing_gain         <= `DCA_RST_SMOOTH;
      primary_input_range_select   <= `DCA_RST_PRIM;
      secondary_input_range_select <= `DCA_RST_SEC;
      thermistor_protect_level     <= `DCA_RST_THERM;
      input_function_assign        <= `DCA_RST_ASSIGN;
      primary_gain_frequency       <= `DCA_RST_GAINF;
      secondary_gain_frequency     <= `DCA_RST_GAINF;
      write_protect_select         <= `DCA_RST_WPROT;
    end else if (wr & wr_open) begin
      case (wb_adr_i)
        `DCA_OFS_CARRIER: begin
          carrier_freq_select        <= nw[3:0]; // see RULE3
          soft_carrier_select        <= nw[`DCA_F_SOFT];
          carrier_auto_reduce_select <= nw[`DCA_F_AUTO];
        end
        `DCA_OFS_SMOOTH: begin
          if (nw[7:0] <= `DCA_SMOOTH_MAX) begin
            speed_smoothing_gain <= nw[7:0]; // see RULE7
          end
        end
        `DCA_OFS_RANGE: begin
          if (dca_prim_ok(nw[3:0]) && nw[7:4] == 4'h0) begin
            primary_input_range_select <= nw[3:0]; // see RULE9
          end
          if (nw[9:8] != 2'h3 && nw[15:10] == 6'h00) begin
            secondary_input_range_select <= nw[9:8]; // see RULE10
          end
        end
        `DCA_OFS_THERM: begin
          thermistor_protect_level <= nw[15:0];
        end
        `DCA_OFS_ASSIGN: begin
          input_function_assign <= nw[24:0];
        end
        `DCA_OFS_GAINF: begin
          if (nw[11:0] <= `DCA_GAINF_MAX) begin
            primary_gain_frequency <= nw[11:0]; // see RULE14
          end
          if (nw[27:16] <= `DCA_GAINF_MAX) begin
            secondary_gain_frequency <= nw[27:16];
          end
        end
        `DCA_OFS_WPROT: begin
          write_protect_select <= nw[1:0];
        end
        default: ;
      endcase
    end
  end

  // Load watch; a short dip restarts the hold so only sustained load reduces
  // Judged on the configured code, not the reduced one, or it would release itself
  // Limitation: one cycle below the limit restarts the whole hold
  always @(posedge clk_i) begin
    if (rst_i) begin
      hold_cnt <= 16'h0000;
      reduced  <= 1'b0;
    end else if (~carrier_auto_reduce_select
                 || carrier_freq_select < `DCA_CARR_MIN_RED) begin
      hold_cnt <= 16'h0000; // see RULE2
      reduced  <= 1'b0;
    end else if (load_pct_i >= `DCA_LOAD_LIMIT) begin
      if (hold_cnt == `DCA_HOLD_CYC - 1) begin
        reduced <= 1'b1; // see RULE1
      end else begin
        hold_cnt <= hold_cnt + 16'h0001; // see RULE4
      end
    end else begin
      hold_cnt <= 16'h0000;
      reduced  <= 1'b0;
    end
  end

  // Running mean of load, 16 samples deep
  always @(posedge clk_i) begin
    if (rst_i) begin
      load_avg <= 12'h000;
    end else begin
      load_avg <= load_avg - {4'h0, load_avg[11:4]} + {4'h0, load_pct_i};
    end
  end

  // Command pipeline stage ahead of smoothing
  always @(posedge clk_i) begin
    if (rst_i) begin
      main_cmd <= 16'h0000;
    end else begin
      main_cmd <= next_main_cmd;
    end
  end

  // Registered outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      carrier_code_o     <= `DCA_RST_CARRIER;
      carrier_tenths_o   <= 8'h0a;
      soft_carrier_en_o  <= 1'b0;
      sec_current_mode_o <= 1'b0;
      main_src_sec_o     <= 1'b0;
      reversible_o       <= 1'b0;
      freq_cmd_o         <= 16'h0000;
    end else begin
      carrier_code_o     <= eff_code; // see RULE1
      carrier_tenths_o   <= dca_tenths(eff_code); // see RULE3
      soft_carrier_en_o  <= soft_carrier_select & (eff_code <= `DCA_CARR_SOFT_MAX);
      sec_current_mode_o <= sec_mode == 2'h2; // see RULE10
      main_src_sec_o     <= use_sec; // see RULE11
      reversible_o       <= rev;
      freq_cmd_o         <= next_freq; // see RULE7
    end
  end

endmodule

// File: tb/dca_monitor.sv
module dca_monitor (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire [7:0]  load_pct_i,
  input wire [4:0]  din_i,
  input wire [3:0]  carrier_code_o,
  input wire [7:0]  carrier_tenths_o,
  input wire        sec_current_mode_o,
  input wire        main_src_sec_o,
  input wire        reversible_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] hi_cnt;
  reg [7:0] idle_cnt;
  // Saturating run lengths, so a bus write is not mistaken for a reduction
  always @(posedge clk_i) begin
    if (rst_i || load_pct_i < 8'h55) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
    if (rst_i || wb_cyc_i) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  tenths_map_a: assert property (carrier_tenths_o == ((carrier_code_o == 4'h0) ? 8'h07 :
    (carrier_code_o == 4'hf) ? 8'h91 : {4'h0, carrier_code_o} * 8'h0a))
    else $error("carrier tenths mismatch");
  reduce_wait_a: assert property ($rose(carrier_code_o == 4'h2) && idle_cnt > 8'h04
    |-> hi_cnt >= 8'd125)
    else $error("carrier dropped too early");
  load_calm_a: assert property ((!wb_cyc_i && load_pct_i < 8'h55)[*5]
    |-> $stable(carrier_code_o))
    else $error("carrier moved under light load");
  src_steady_a: assert property ((!wb_cyc_i && $stable(din_i))[*4]
    |-> $stable(main_src_sec_o))
    else $error("source moved with no cause");
  range_steady_a: assert property ((!wb_cyc_i)[*4]
    |-> $stable(reversible_o) && $stable(sec_current_mode_o))
    else $error("range outputs moved with no cause");
  cv_reduce: cover property ($rose(carrier_code_o == 4'h2) && idle_cnt > 8'h04);
  cv_rev: cover property ($rose(reversible_o));
  cv_sec: cover property ($rose(main_src_sec_o));
endmodule

bind dca_top dca_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .load_pct_i(load_pct_i),
  .din_i(din_i), .carrier_code_o(carrier_code_o), .carrier_tenths_o(carrier_tenths_o),
  .sec_current_mode_o(sec_current_mode_o), .main_src_sec_o(main_src_sec_o),
  .reversible_o(reversible_o));

// File: tb/dca_src.sv
module dca_src (
  input  wire       clk_i,
  input  wire [9:0] prim_lvl_i,
  input  wire [9:0] sec_lvl_i,
  input  wire [4:0] contacts_i,
  output reg  [9:0] prim_adc_o,
  output reg  [9:0] sec_adc_o,
  output reg  [4:0] din_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Converter and contact sampling take one clock, like a real front end
  always @(posedge clk_i) begin
    prim_adc_o <= prim_lvl_i;
    sec_adc_o  <= sec_lvl_i;
    din_o      <= contacts_i;
  end
endmodule

// File: tb/tb.sv
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, run_i = 0;
  reg [7:0] adr = 8'h00, load = 8'h00;
  reg [31:0] dat = 32'h0, rdat;
  reg [9:0] prim_lvl = 10'h000, sec_lvl = 10'h0cd;
  reg [4:0] contacts = 5'h00;
  wire [9:0] prim_adc, sec_adc;
  wire [4:0] din;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, soft_en, sec_cur, src_sec, rev;
  wire [3:0] code;
  wire [7:0] tenths;
  wire [15:0] freq;
  int fails = 0;
  int total_checks = 0;
  dca_src u_src (.clk_i(clk_i), .prim_lvl_i(prim_lvl), .sec_lvl_i(sec_lvl),
    .contacts_i(contacts), .prim_adc_o(prim_adc), .sec_adc_o(sec_adc), .din_o(din));
  dca_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .run_i(run_i), .load_pct_i(load), .din_i(din), .prim_adc_i(prim_adc), .sec_adc_i(sec_adc),
    .carrier_code_o(code), .carrier_tenths_o(tenths), .soft_carrier_en_o(soft_en),
    .sec_current_mode_o(sec_cur), .main_src_sec_o(src_sec), .reversible_o(rev),
    .freq_cmd_o(freq));
  always #4 clk_i = ~clk_i;
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One classic cycle; held until ack is seen high at an edge
  task acc(input [7:0] a, input w, input [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
    do tick(1); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    @(posedge clk_i);
    {cyc, stb, we} <= 3'b000;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    acc(a, 1'b1, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    acc(a, 1'b0, 32'h0);
    `CHK(rdat, e)
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    results();
  end
  initial begin
    bit [31:0] rv [9] = '{32'h011, 0, 32'h001, 32'h270f, 0, 32'h01f401f4, 0, 32'h000a0001, 0};
    bit [3:0] cs [3] = '{4'h0, 4'hf, 4'h7};
    bit [7:0] ct [3] = '{8'h07, 8'h91, 8'h46};
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    // Reset values, status and one unmapped offset
    for (int i = 0; i < 9; i++) rd(8'(i * 4), rv[i]);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, {28'h1, cs[i]});
      tick(4);
      `CHK(tenths, ct[i])
      `CHK(soft_en, cs[i] <= 4'h5)
    end
    wr(8'h08, 32'h10a);
    tick(4);
    `CHK({rev, sec_cur}, 2'b10)
    wr(8'h08, 32'h105);
    rd(8'h08, 32'h10a);
    wr(8'h08, 32'h000);
    prim_lvl <= 10'h3ff;
    tick(8);
    `CHK({rev, sec_cur}, 2'b01)
    `CHK(freq, 16'h01f3)
    wr(8'h14, 32'h01f403e8);
    tick(8);
    `CHK(freq, 16'h03e7)
    wr(8'h0c, 32'h64);
    tick(8);
    `CHK(freq, 16'h0000)
    wr(8'h0c, 32'h270f);
    wr(8'h08, 32'h00a);
    prim_lvl <= 10'h000;
    tick(8);
    `CHK(freq, 16'hfc18)
    wr(8'h10, 32'h1000);
    contacts <= 5'h04;
    tick(8);
    `CHK({src_sec, rev}, 2'b11)
    contacts <= 5'h01;
    tick(8);
    `CHK({src_sec, rev}, 2'b01)
    // Load exactly at the threshold, then one below it
    wr(8'h00, 32'h115);
    load <= 8'h55;
    tick(140);
    `CHK({code, tenths}, 12'h214)
    load <= 8'h54;
    tick(4);
    `CHK(code, 4'h5)
    wr(8'h00, 32'h015);
    load <= 8'h55;
    tick(140);
    `CHK(code, 4'h5)
    run_i <= 1;
    wr(8'h04, 32'h64);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h017);
    rd(8'h00, 32'h017);
    wr(8'h18, 32'h2);
    wr(8'h04, 32'h64);
    rd(8'h04, 32'h64);
    wr(8'h04, 32'hc9);
    rd(8'h04, 32'h64);
    results();
  end
endmodule
